// >>> src/gfmc_ctrl.sv
/*
 aux output pins and frequency modulation control.
 assumes a single-cycle register port on core_clk_in and a downstream
 synthesizer that adds freq_offset_out to its nominal fractional word.
*/
// Chosen here: the register offsets and the strobed register port.
// Contract
// - aux pins are driven from a software-written output-pin register.
// - the register holds path 1 and path 2 pin states, the path-select level picks one.
// - mode field 11 enters binary fsk and turns aux pin three into an input.
// - in fsk the level on aux pin three picks nominal or deviated frequency.
// - deviation comes from the step-scale field and the signed modulation word together.
// - deviation equals 2^step times phase detector rate times word over 2^16, word signed; the code shifts by the low 3 bits of the 4-bit step field only.
// - mode field 01 is continuous modulation governed by the current word.
// - in continuous mode each new word takes effect at once with no trigger.
// - the path-select level picks the active mixer path and register bank.
`timescale 1ns/100ps
`include "gfmc_cfg.svh"
module gfmc_ctrl #(
   parameter int AUX_W  = 6,
   parameter int STEP_W = 3,
   parameter int OFS_W  = 40
) (
   // clock and reset
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_in,
   // register port
   input  wire logic [`GFMC_ADDR_W-1:0] addr_in,
   input  wire logic [15:0]          wdata_in,
   input  wire logic                 wr_in,
   input  wire logic                 rd_in,
   output logic      [15:0]          rdata_out,
   // pins
   input  wire logic                 path_sel_in,
   input  wire logic                 aux_pin_three_in,
   output logic      [AUX_W-1:0]     aux_output_pins_out,
   output logic      [AUX_W-1:0]     aux_output_pins_oe_out,
   // synthesizer side
   output logic                      path2_active_out,
   output logic signed [OFS_W-1:0]   freq_offset_out
);
   import gfmc_pkg::*;

   typedef struct packed {
      logic [1:0]              psel_s;
      logic [1:0]              fsk_s;
      logic [7:0]              aux_p1;
      logic [7:0]              aux_p2;
      gfmc_mode_t              mod_mode_sel;
      logic [3:0]              mod_step_scale;
      logic [15:0]             mod_value_reg;
      gfmc_state_e             st;
      logic [15:0]             rdata;
      logic [AUX_W-1:0]        pins;
      logic [AUX_W-1:0]        oe;
      logic                    path2;
      logic signed [OFS_W-1:0] ofs;
   } gfmc_state_s;

   gfmc_state_s r_q, r_d;
   logic signed [OFS_W-1:0] dev;
   logic [7:0]              sel_pins;

   // deviation in units of fpd/2^16
   always_comb begin
      dev = OFS_W'(signed'(r_q.mod_value_reg)) <<< r_q.mod_step_scale[STEP_W-1:0];
   end

   always_comb begin
      r_d = r_q;
      // two-flop synchronisers on the pin inputs
      r_d.psel_s = {r_q.psel_s[0], path_sel_in};
      r_d.fsk_s  = {r_q.fsk_s[0], aux_pin_three_in};
      if (wr_in) begin
         case (addr_in)
            `GFMC_OFS_AUX: begin
               r_d.aux_p1 = wdata_in[`GFMC_AUX_P1_LSB +: 8];
               r_d.aux_p2 = wdata_in[`GFMC_AUX_P2_LSB +: 8];
            end
            `GFMC_OFS_SETUP: begin
               r_d.mod_mode_sel   = wdata_in[`GFMC_SETUP_MODE_LSB +: 2];
               r_d.mod_step_scale = wdata_in[`GFMC_SETUP_STEP_LSB +: 4];
            end
            `GFMC_OFS_VALUE: r_d.mod_value_reg = wdata_in;
            default: ;
         endcase
      end
      // read data stands one cycle only, zero otherwise
      r_d.rdata = 16'h0000;
      if (rd_in) begin
         case (addr_in)
            `GFMC_OFS_AUX:    r_d.rdata = {r_q.aux_p2, r_q.aux_p1};
            `GFMC_OFS_SETUP:  r_d.rdata = {8'h00, r_q.mod_step_scale, 2'h0, r_q.mod_mode_sel};
            `GFMC_OFS_VALUE:  r_d.rdata = r_q.mod_value_reg;
            `GFMC_OFS_STATUS: r_d.rdata = {10'h000, r_q.st, r_q.fsk_s[1], r_q.path2, r_q.psel_s[1]};
            default:          r_d.rdata = 16'h0000;
         endcase
      end
      case (r_q.mod_mode_sel)
         `GFMC_MODE_FSK:  r_d.st = GFMC_FSK;
         `GFMC_MODE_CONT: r_d.st = GFMC_CONT;
         default:         r_d.st = GFMC_OFF;
      endcase
      r_d.path2 = r_q.psel_s[1];
      sel_pins = r_q.psel_s[1] ? r_q.aux_p2 : r_q.aux_p1;
      r_d.pins = sel_pins[AUX_W-1:0];
      r_d.oe   = '1;
      if (r_q.st == GFMC_FSK) begin
         r_d.oe[2]   = 1'b0;
         r_d.pins[2] = 1'b0;
      end
      case (r_q.st)
         GFMC_FSK:  r_d.ofs = r_q.fsk_s[1] ? dev : '0;
         GFMC_CONT: r_d.ofs = dev;
         GFMC_OFF:  r_d.ofs = '0;
         default:   r_d.ofs = '0;
      endcase
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         // register field reset values come from the config header; st and oe are fixed here
         r_q                <= '0;
         r_q.aux_p1         <= 8'(`GFMC_RST_AUX >> `GFMC_AUX_P1_LSB);
         r_q.aux_p2         <= 8'(`GFMC_RST_AUX >> `GFMC_AUX_P2_LSB);
         r_q.mod_mode_sel   <= 2'(`GFMC_RST_SETUP >> `GFMC_SETUP_MODE_LSB);
         r_q.mod_step_scale <= 4'(`GFMC_RST_SETUP >> `GFMC_SETUP_STEP_LSB);
         r_q.mod_value_reg  <= `GFMC_RST_VALUE;
         r_q.st             <= GFMC_OFF;
         r_q.oe             <= '1;
      end else begin
         r_q <= r_d;
      end
   end

   assign rdata_out              = r_q.rdata;
   assign aux_output_pins_out    = r_q.pins;
   assign aux_output_pins_oe_out = r_q.oe;
   assign path2_active_out       = r_q.path2;
   assign freq_offset_out        = r_q.ofs;

   // checks
   fsk_pin_input_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st == GFMC_FSK) |=> !aux_output_pins_oe_out[2])
      else $error("pin three driven in fsk");
   nonfsk_pin_out_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st != GFMC_FSK) |=> aux_output_pins_oe_out[2])
      else $error("pin three released outside fsk");
   path_pins_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st != GFMC_FSK && r_q.psel_s[1]) |=> aux_output_pins_out == r_q.aux_p2[AUX_W-1:0] || $changed(r_q.aux_p2))
      else $error("path 2 pins wrong");
   pin_sync_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      path_sel_in ##1 path_sel_in ##1 path_sel_in |=> path2_active_out)
      else $error("path select not followed");
   cont_word_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wr_in && addr_in == `GFMC_OFS_VALUE && r_q.mod_mode_sel == `GFMC_MODE_CONT)
      |=> ##1 freq_offset_out ==
         (OFS_W'(signed'($past(wdata_in, 2))) <<< $past(r_q.mod_step_scale[STEP_W-1:0])))
      else $error("word not applied");
   off_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st == GFMC_OFF) |=> freq_offset_out == '0)
      else $error("offset outside modulation");
   fsk_nominal_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st == GFMC_FSK && !r_q.fsk_s[1]) |=> freq_offset_out == '0)
      else $error("fsk low not nominal");
   fsk_dev_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st == GFMC_FSK && r_q.fsk_s[1]) |=> freq_offset_out == $past(dev))
      else $error("fsk deviation wrong");
   mode_dec_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.mod_mode_sel == `GFMC_MODE_CONT) |=> r_q.st == GFMC_CONT)
      else $error("continuous mode not entered");

   // register port checks
   rdata_idle_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !rd_in |=> rdata_out == 16'h0000)
      else $error("read data outside read cycle");
   value_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (rd_in && addr_in == `GFMC_OFS_VALUE) |=> rdata_out == $past(r_q.mod_value_reg))
      else $error("modulation word readback wrong");
   unmapped_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (rd_in && addr_in > `GFMC_OFS_STATUS) |=> rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   aux_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wr_in && addr_in == `GFMC_OFS_AUX) |=> {r_q.aux_p2, r_q.aux_p1} == $past(wdata_in))
      else $error("pin register write lost");
   setup_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wr_in && addr_in == `GFMC_OFS_SETUP) |=> r_q.mod_step_scale == $past(wdata_in[`GFMC_SETUP_STEP_LSB +: 4]))
      else $error("step scale write lost");
   value_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wr_in && addr_in == `GFMC_OFS_VALUE) |=> r_q.mod_value_reg == $past(wdata_in))
      else $error("modulation word write lost");

   // pin and modulation checks
   path1_pins_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st != GFMC_FSK && !r_q.psel_s[1]) |=> aux_output_pins_out == $past(r_q.aux_p1[AUX_W-1:0]))
      else $error("path 1 pins wrong");
   fsk_pin_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st == GFMC_FSK) |=> !aux_output_pins_out[2])
      else $error("released pin three not low");
   path_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !path_sel_in ##1 !path_sel_in ##1 !path_sel_in |=> !path2_active_out)
      else $error("path select low not followed");
   cont_offset_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.st == GFMC_CONT) |=> freq_offset_out == $past(dev))
      else $error("continuous offset wrong");
   fsk_mode_dec_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.mod_mode_sel == `GFMC_MODE_FSK) |=> r_q.st == GFMC_FSK)
      else $error("fsk mode not entered");
   off_mode_dec_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (r_q.mod_mode_sel != `GFMC_MODE_FSK && r_q.mod_mode_sel != `GFMC_MODE_CONT)
      |=> r_q.st == GFMC_OFF)
      else $error("off mode not entered");

   cov_fsk_c: cover property (@(posedge core_clk_in) r_q.st == GFMC_FSK && r_q.fsk_s[1]);
   cov_cont_c: cover property (@(posedge core_clk_in) r_q.st == GFMC_CONT && freq_offset_out != '0);
   cov_path2_c: cover property (@(posedge core_clk_in) path2_active_out);
   cov_fsk_nominal_c: cover property (@(posedge core_clk_in) r_q.st == GFMC_FSK && !r_q.fsk_s[1]);
   cov_bad_read_c: cover property (@(posedge core_clk_in) rd_in && addr_in > `GFMC_OFS_STATUS);
endmodule

// >>> inc/gfmc_cfg.svh
/*
 constants for the aux output and modulation control block.
 assumes inclusion by the design file only; the package does not include it.
*/
`ifndef GFMC_CFG_SVH
`define GFMC_CFG_SVH
`define GFMC_ADDR_W        4
`define GFMC_OFS_AUX       4'h0
`define GFMC_OFS_SETUP     4'h1
`define GFMC_OFS_VALUE     4'h2
`define GFMC_OFS_STATUS    4'h3
`define GFMC_AUX_P1_LSB    0
`define GFMC_AUX_P2_LSB    8
`define GFMC_SETUP_MODE_LSB 0
`define GFMC_SETUP_STEP_LSB 4
`define GFMC_MODE_FSK      2'h3
`define GFMC_MODE_CONT     2'h1
`define GFMC_RST_AUX       16'h0000
`define GFMC_RST_SETUP     8'h00
`define GFMC_RST_VALUE     16'h0000
`define GFMC_FRAC_BITS     16
`endif

// >>> inc/gfmc_pkg.sv
/*
 types for the aux output and modulation control block.
 assumes gfmc_cfg.svh is on the include path.
*/
package gfmc_pkg;
   typedef logic [1:0] gfmc_mode_t;
   typedef enum logic [2:0] {
      GFMC_OFF  = 3'b001,
      GFMC_CONT = 3'b010,
      GFMC_FSK  = 3'b100
   } gfmc_state_e;
endpackage

// >>> test/gfmc_host.sv
/*
 host controller model driving the register port of the control block.
 assumes the bench supplies the clock and reads results through rd_reg.
*/
`timescale 1ns/100ps
module gfmc_host (
   // clock and read data
   input  wire logic        clk_in,
   input  wire logic [15:0] rdata_in,
   // register port
   output logic      [3:0]  addr_out,
   output logic      [15:0] wdata_out,
   output logic             wr_out,
   output logic             rd_out
);
   initial begin
      addr_out = 4'h0;
      wdata_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask
endmodule

// >>> test/gfmc_ctrl_test.sv
/*
 self-checking bench for the aux pin and modulation control block.
 assumes the host model drives the register port.
*/
`timescale 1ns/100ps
module gfmc_ctrl_test;
   logic               core_clk_in;
   logic               rst_in;
   logic               path_sel;
   logic               pin3;
   logic               wr;
   logic               rdn;
   logic               p2;
   logic [3:0]         addr;
   logic [15:0]        wdata;
   logic [15:0]        rdata;
   logic [15:0]        rd;
   logic [15:0]        aux;
   logic [15:0]        word;
   logic [1:0]         mode;
   logic [2:0]         step;
   logic [5:0]         pins;
   logic [5:0]         oe;
   logic signed [39:0] ofs;
   int                 n_mismatch = 0;
   int                 check_count = 0;
   gfmc_host host (.clk_in(core_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rdn));
   gfmc_ctrl dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rdn), .rdata_out(rdata), .path_sel_in(path_sel), .aux_pin_three_in(pin3),
      .aux_output_pins_out(pins), .aux_output_pins_oe_out(oe), .path2_active_out(p2),
      .freq_offset_out(ofs));
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic check_out;
      logic [5:0] e;
      longint     o;
      e = path_sel ? aux[13:8] : aux[5:0];
      if (mode == 2'h3) e[2] = 1'b0;
      o = (mode == 2'h1 || (mode == 2'h3 && pin3)) ? (longint'($signed(word)) <<< step) : 0;
      chk(pins, e);
      chk(oe, (mode == 2'h3) ? 6'h3b : 6'h3f);
      chk(ofs, o[39:0]);
      chk(p2, path_sel);
   endtask
   task automatic print_verdict;
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end
   initial begin
      rst_in = 1'b1;
      path_sel = 1'b0;
      pin3 = 1'b0;
      {aux, word, mode, step} = '0;
      void'($urandom(32'h5accad6b));
      repeat (2) @(posedge core_clk_in);
      rst_in <= 1'b0;
      #1 check_out;
      repeat (6) begin
         aux = 16'($urandom);
         word = 16'($urandom);
         step = 3'($urandom);
         host.wr_reg(4'h0, aux);
         host.wr_reg(4'h2, word);
         for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            host.wr_reg(4'h1, {8'h00, 1'b0, step, 2'b00, mode});
            for (int k = 0; k < 4; k++) begin
               @(posedge core_clk_in);
               path_sel <= k[0];
               pin3 <= k[1];
               repeat (4) @(posedge core_clk_in);
               #1 check_out;
            end
            host.rd_reg(4'h3, rd);
            chk(rd[5:0], {(mode == 2'h3) ? 3'h4 : (mode == 2'h1) ? 3'h2 : 3'h1, pin3, path_sel, path_sel});
            host.rd_reg(4'h1, rd);
            chk(rd, {8'h00, 1'b0, step, 2'b00, mode});
         end
         host.rd_reg(4'h2, rd);
         chk(rd, word);
         host.rd_reg(4'h5, rd);
         chk(rd, 16'h0000);
      end
      mode = 2'h1;
      host.wr_reg(4'h1, {8'h00, 1'b0, step, 2'b00, mode});
      repeat (8) begin
         word = 16'($urandom);
         host.wr_reg(4'h2, word);
         @(posedge core_clk_in);
         #1 check_out;
      end
      @(posedge core_clk_in);
      rst_in <= 1'b1;
      path_sel <= 1'b0;
      pin3 <= 1'b0;
      {aux, word, mode, step} = '0;
      repeat (2) @(posedge core_clk_in);
      rst_in <= 1'b0;
      #1 check_out;
      host.rd_reg(4'h1, rd);
      chk(rd, 16'h0000);
      repeat (4) @(posedge core_clk_in);
      #1 check_out;
      print_verdict;
   end
endmodule
